// File: rtl/fbio_regbank.sv
// Register bank and fault response of the fieldbus digital I/O station
// ------------------------------------------------------------
// What this block does
// - On communication failure all outputs take the configured substitute behaviour.
// - Up to eight client connections served, each addressing any register.
// - Conformity classes 0 and 1 fully, class 2 partly.
// - Only function codes 1,2,3,4,5,6,15,16,23 accepted; others get exception.
// - Output word readable and writable by bit or word; input word read-only.
// - Writes to read-only registers change nothing and answer exception 02.
// - Connection timeout in ms; zero disables; only zero or 200..65000 allowed.
// - New connection timeout applies after a function completes on that connection.
// - Watchdog timeout in ms; zero keeps it from arming but cannot stop an armed one; only zero or 200..65000 allowed.
// - Fault response mode register is readable and writable by word codes.
// - Mode 0 drives outputs low, 1 high, 2 holds last values.
// - Cause of latest fault kept in a read-only register.
// - Cause codes 7 to 13 name the fault source; 1 to 6 reserved.
// - Command register write-only; more than one set bit reports an error.
// - Command bit 4 forces network failure; bit 5 acknowledges and clears it.
// - Command bit 7 clears detected I/O warnings; other bits reserved.
// - Watchdog starts on first output write, restarts on writes, never on reads.
// - Watchdog expiry applies substitute values and sets status bit 1.
// - In automatic mode the next output write clears network failure.
// - Status bit 1 reads one exactly while network failure is active.
// ------------------------------------------------------------
`timescale 1ns/1ns
module fbio_regbank
    import fbio_pkg::*;
#(
    parameter int unsigned MS_CYCLES = MS_CYCLES_DFLT
)
(
    input wire logic mclk_in,
    input wire logic rstn_in,
    input wire fbio_req_t req_in,
    output fbio_rsp_t rsp_out,
    input wire logic [7:0] din_in,
    input wire fbio_evt_t evt_in,
    input wire logic [NUM_CONN-1:0] conn_close_in,
    input wire logic auto_ack_in,
    input wire logic [15:0] diag_status_in,
    input wire logic [15:0] diag_param_in,
    output logic [NUM_DOUT-1:0] dout_out,
    output logic net_fail_out,
    output logic io_warn_out
);

    // ------------------------------------------------------------
    // Function code classes
    // ------------------------------------------------------------
    function automatic logic fc_is_write(input logic [7:0] fc);
        return (fc == FC_WR_COIL) || (fc == FC_WR_REG) || (fc == FC_WR_COILS) ||
               (fc == FC_WR_REGS) || (fc == FC_RW_REGS);
    endfunction

    function automatic logic fc_is_read(input logic [7:0] fc);
        return (fc == FC_RD_COILS) || (fc == FC_RD_DISCR) || (fc == FC_RD_HOLD) ||
               (fc == FC_RD_INPUT) || (fc == FC_RW_REGS);
    endfunction

    function automatic logic fc_is_bit(input logic [7:0] fc);
        return (fc == FC_RD_COILS) || (fc == FC_RD_DISCR) || (fc == FC_WR_COIL) ||
               (fc == FC_WR_COILS);
    endfunction

    function automatic logic tmo_ok(input logic [15:0] v);
        return (v == TMO_OFF) || ((v >= TMO_MIN_MS) && (v <= TMO_MAX_MS));
    endfunction

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [15:0] conn_mon_ff;
    logic [15:0] wdog_tmo_ff;
    logic [15:0] fault_sel_ff;
    logic [15:0] cause_ff;
    logic [15:0] out_word_ff;
    logic net_fail_ff;
    logic io_warn_ff;
    logic wd_armed_ff;
    logic [15:0] wd_cnt_ff;
    logic [15:0] wd_lim_ff;
    logic [NUM_CONN-1:0] cm_act_ff;
    logic [15:0] cm_cnt_ff [NUM_CONN];
    logic [15:0] cm_lim_ff [NUM_CONN];
    logic ms_tick;

    fbio_ms_tick #(.CYCLES(MS_CYCLES)) u_tick
    (
        .mclk_in(mclk_in),
        .rstn_in(rstn_in),
        .tick_out(ms_tick)
    );

    // ------------------------------------------------------------
    // Request decode
    // ------------------------------------------------------------
    logic fc_known;
    logic is_wr;
    logic is_rd;
    logic is_bit;
    logic map_ok;
    logic val_ok;
    logic [7:0] exc;
    logic acc_ok;
    logic [15:0] wr_val;
    logic [15:0] rd_word;

    assign is_wr = fc_is_write(req_in.fc);
    assign is_rd = fc_is_read(req_in.fc);
    assign is_bit = fc_is_bit(req_in.fc);
    assign fc_known = is_wr || is_rd;

    always_comb
    begin
        map_ok = 1'b0;
        val_ok = 1'b1;
        rd_word = WORD_RST;
        case (req_in.addr)
            ADDR_CONN_MON:
            begin
                map_ok = !is_bit;
                val_ok = tmo_ok(req_in.wdata) || !is_wr;
                rd_word = conn_mon_ff;
            end
            ADDR_WDOG_TMO:
            begin
                map_ok = !is_bit;
                val_ok = tmo_ok(req_in.wdata) || !is_wr;
                rd_word = wdog_tmo_ff;
            end
            ADDR_FAULT_SEL:
            begin
                map_ok = !is_bit;
                val_ok = (req_in.wdata <= MODE_HOLD) || !is_wr;
                rd_word = fault_sel_ff;
            end
            ADDR_CAUSE:
            begin
                map_ok = !is_bit && !is_wr;
                rd_word = cause_ff;
            end
            ADDR_COMMAND:
            begin
                // Write-only: plain reads refused, FC23 reads back zero
                map_ok = !is_bit && is_wr;
                val_ok = ($countones(req_in.wdata) == 1);
            end
            ADDR_STATUS:
            begin
                map_ok = !is_bit && !is_wr;
                rd_word[STAT_ERR_BIT] = io_warn_ff || (diag_status_in != WORD_RST);
                rd_word[STAT_FAIL_BIT] = net_fail_ff;
            end
            ADDR_DIAG_STAT:
            begin
                map_ok = !is_bit && !is_wr;
                rd_word = diag_status_in;
            end
            ADDR_DIAG_PARAM:
            begin
                map_ok = !is_bit && !is_wr;
                rd_word = diag_param_in;
            end
            ADDR_IN_WORD:
            begin
                map_ok = !is_wr;
                rd_word = {8'h00, din_in};
            end
            ADDR_OUT_WORD:
            begin
                map_ok = 1'b1;
                rd_word = out_word_ff;
            end
            default:
            begin
                map_ok = 1'b0;
            end
        endcase
        if (!fc_known)
            exc = EXC_BAD_FC;
        else if (!map_ok)
            exc = EXC_BAD_ADDR;
        else if (!val_ok)
            exc = EXC_BAD_VALUE;
        else
            exc = EXC_NONE;
    end

    assign acc_ok = req_in.valid && (exc == EXC_NONE);

    // Bit writes merge one coil into the stored word
    always_comb
    begin
        wr_val = req_in.wdata;
        if (is_bit)
        begin
            wr_val = out_word_ff;
            wr_val[req_in.bit_idx] = req_in.wdata[0];
        end
    end

    logic wr_conn_mon;
    logic wr_wdog;
    logic wr_sel;
    logic wr_cmd;
    logic wr_out;

    assign wr_conn_mon = acc_ok && is_wr && (req_in.addr == ADDR_CONN_MON);
    assign wr_wdog = acc_ok && is_wr && (req_in.addr == ADDR_WDOG_TMO);
    assign wr_sel = acc_ok && is_wr && (req_in.addr == ADDR_FAULT_SEL);
    assign wr_cmd = acc_ok && is_wr && (req_in.addr == ADDR_COMMAND);
    assign wr_out = acc_ok && is_wr && (req_in.addr == ADDR_OUT_WORD);

    // ------------------------------------------------------------
    // Response, one cycle after the request; all connections share it
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            rsp_out <= '0;
        end
        else
        begin
            rsp_out.valid <= req_in.valid;
            rsp_out.conn <= req_in.conn;
            rsp_out.exc <= exc;
            if (exc != EXC_NONE || !is_rd)
                rsp_out.rdata <= WORD_RST;
            else if (is_bit)
                rsp_out.rdata <= {15'h0000, rd_word[req_in.bit_idx]};
            else
                rsp_out.rdata <= rd_word;
        end
    end

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            conn_mon_ff <= TMO_OFF;
            wdog_tmo_ff <= TMO_OFF;
            fault_sel_ff <= MODE_LOW;
            out_word_ff <= WORD_RST;
        end
        else
        begin
            if (wr_conn_mon)
                conn_mon_ff <= req_in.wdata;
            if (wr_wdog)
                wdog_tmo_ff <= req_in.wdata;
            if (wr_sel)
                fault_sel_ff <= req_in.wdata;
            // Output data keeps updating during a failure; it is shown after ack
            if (wr_out)
                out_word_ff <= wr_val;
        end
    end

    // ------------------------------------------------------------
    // Process-data watchdog
    // ------------------------------------------------------------
    logic wd_expire;
    logic fail_clr;
    assign wd_expire = wd_armed_ff && !net_fail_ff && ms_tick &&
                       ((wd_cnt_ff + 16'h0001) >= wd_lim_ff);

    // Once armed it cannot be stopped; a zero write leaves the live limit
    always_ff @(posedge mclk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            wd_armed_ff <= 1'b0;
            wd_cnt_ff <= 16'h0000;
            wd_lim_ff <= TMO_OFF;
        end
        else if (wr_out && wdog_tmo_ff != TMO_OFF)
        begin
            wd_armed_ff <= 1'b1;
            wd_cnt_ff <= 16'h0000;
            wd_lim_ff <= wdog_tmo_ff;
        end
        else if (wr_out || fail_clr)
        begin
            wd_cnt_ff <= 16'h0000;
        end
        else if (wd_expire)
        begin
            wd_cnt_ff <= 16'h0000;
        end
        else if (wd_armed_ff && !net_fail_ff && ms_tick)
        begin
            wd_cnt_ff <= wd_cnt_ff + 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // Connection monitoring
    // ------------------------------------------------------------
    logic [NUM_CONN-1:0] cm_expire;
    always_comb
    begin
        for (int i = 0; i < NUM_CONN; i++)
            cm_expire[i] = cm_act_ff[i] && ms_tick &&
                           ((cm_cnt_ff[i] + 16'h0001) >= cm_lim_ff[i]);
    end

    always_ff @(posedge mclk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            cm_act_ff <= '0;
            for (int i = 0; i < NUM_CONN; i++)
            begin
                cm_cnt_ff[i] <= 16'h0000;
                cm_lim_ff[i] <= TMO_OFF;
            end
        end
        else
        begin
            for (int i = 0; i < NUM_CONN; i++)
            begin
                if (req_in.valid && req_in.conn == 3'(i))
                begin
                    // Limit in force is taken only when a function completes
                    cm_act_ff[i] <= (conn_mon_ff != TMO_OFF);
                    cm_lim_ff[i] <= conn_mon_ff;
                    cm_cnt_ff[i] <= 16'h0000;
                end
                else if (conn_close_in[i] || cm_expire[i])
                begin
                    cm_act_ff[i] <= 1'b0;
                    cm_cnt_ff[i] <= 16'h0000;
                end
                else if (cm_act_ff[i] && ms_tick)
                begin
                    cm_cnt_ff[i] <= cm_cnt_ff[i] + 16'h0001;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Network failure state and cause
    // ------------------------------------------------------------
    logic cmd_set;
    logic cmd_ack;
    logic cmd_clr_warn;
    logic fail_set;
    logic [15:0] nxt_cause;

    assign cmd_set = wr_cmd && (req_in.wdata == CMD_SET_FAIL);
    assign cmd_ack = wr_cmd && (req_in.wdata == CMD_ACK_FAIL);
    assign cmd_clr_warn = wr_cmd && (req_in.wdata == CMD_CLR_WARN);
    assign fail_clr = net_fail_ff && (cmd_ack || (auto_ack_in && wr_out));

    always_comb
    begin
        fail_set = 1'b1;
        nxt_cause = cause_ff;
        if (wd_expire)
            nxt_cause = CAUSE_WDOG;
        else if (|cm_expire)
            nxt_cause = CAUSE_CONN_TMO;
        else if (cmd_set)
            nxt_cause = CAUSE_USER;
        else if (evt_in.xfer_if_tmo)
            nxt_cause = CAUSE_XFER_IF;
        else if (evt_in.host_tmo)
            nxt_cause = CAUSE_HOST;
        else if (evt_in.conn_abort)
            nxt_cause = CAUSE_ABORT;
        else if (evt_in.init_err)
            nxt_cause = CAUSE_INIT;
        else
            fail_set = 1'b0;
    end

    // A new fault in the acknowledge cycle wins over the clear
    always_ff @(posedge mclk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            net_fail_ff <= 1'b0;
            cause_ff <= CAUSE_NONE;
        end
        else if (fail_set)
        begin
            net_fail_ff <= 1'b1;
            cause_ff <= nxt_cause;
        end
        else if (fail_clr)
        begin
            net_fail_ff <= 1'b0;
        end
    end

    always_ff @(posedge mclk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            io_warn_ff <= 1'b0;
        else if (diag_status_in != WORD_RST)
            io_warn_ff <= 1'b1;
        else if (cmd_clr_warn)
            io_warn_ff <= 1'b0;
    end

    // ------------------------------------------------------------
    // Output drive
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            dout_out <= '0;
            net_fail_out <= 1'b0;
            io_warn_out <= 1'b0;
        end
        else
        begin
            net_fail_out <= net_fail_ff;
            io_warn_out <= io_warn_ff;
            if (!net_fail_ff)
                dout_out <= out_word_ff[NUM_DOUT-1:0];
            else if (fault_sel_ff == MODE_HIGH)
                dout_out <= '1;
            else if (fault_sel_ff == MODE_LOW)
                dout_out <= '0;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rstn_in);

    ro_write_exc_a: assert property (req_in.valid && is_wr && req_in.addr == ADDR_CAUSE
        |=> rsp_out.exc == EXC_BAD_ADDR && rsp_out.valid)
        else $error("write to read-only register not refused");
    bad_fc_exc_a: assert property (req_in.valid && !fc_known
        |=> rsp_out.exc == EXC_BAD_FC)
        else $error("unknown function code not refused");
    tmo_range_a: assert property (req_in.valid && is_wr && req_in.addr == ADDR_WDOG_TMO
        && !is_bit && !tmo_ok(req_in.wdata)
        |=> $stable(wdog_tmo_ff) && rsp_out.exc == EXC_BAD_VALUE)
        else $error("out-of-range timeout stored");
    multi_cmd_a: assert property (req_in.valid && req_in.addr == ADDR_COMMAND && is_wr
        && !is_bit && $countones(req_in.wdata) > 1 && !fail_set |=> $stable(net_fail_ff)
        && rsp_out.exc == EXC_BAD_VALUE)
        else $error("multi-bit command executed");
    cmd_set_a: assert property (cmd_set |=> net_fail_ff)
        else $error("set command ignored");
    cmd_ack_a: assert property (cmd_ack && !fail_set |=> !net_fail_ff)
        else $error("acknowledge command ignored");
    fail_low_a: assert property (net_fail_ff && fault_sel_ff == MODE_LOW
        |=> dout_out == '0)
        else $error("outputs not low in failure");
    fail_high_a: assert property (net_fail_ff && fault_sel_ff == MODE_HIGH
        |=> dout_out == '1)
        else $error("outputs not high in failure");
    fail_hold_a: assert property (net_fail_ff && fault_sel_ff == MODE_HOLD
        ##1 net_fail_ff |=> $stable(dout_out))
        else $error("outputs not held in failure");
    wd_expiry_a: assert property (wd_expire |=> net_fail_ff && cause_ff == CAUSE_WDOG
        ##1 net_fail_out)
        else $error("watchdog expiry not reported");
    status_bit_a: assert property (req_in.valid && is_rd && req_in.addr == ADDR_STATUS
        && !is_bit && !is_wr |=> rsp_out.rdata[STAT_FAIL_BIT] == $past(net_fail_ff))
        else $error("status failure bit wrong");

    wd_fire_c: cover property (wd_expire ##1 net_fail_ff);
    auto_ack_c: cover property (net_fail_ff && auto_ack_in && wr_out ##1 !net_fail_ff);
    conn_tmo_c: cover property (|cm_expire ##1 cause_ff == CAUSE_CONN_TMO);

endmodule

// File: rtl/fbio_pkg.sv
// Package: constants and carrier types for the fieldbus I/O register bank
package fbio_pkg;

    // ------------------------------------------------------------
    // Register numbers
    // ------------------------------------------------------------
    localparam logic [15:0] ADDR_CONN_MON = 16'h0500;
    localparam logic [15:0] ADDR_WDOG_TMO = 16'h07d0;
    localparam logic [15:0] ADDR_FAULT_SEL = 16'h07d2;
    localparam logic [15:0] ADDR_CAUSE = 16'h07d4;
    localparam logic [15:0] ADDR_COMMAND = 16'h07d6;
    localparam logic [15:0] ADDR_STATUS = 16'h1f3c;
    localparam logic [15:0] ADDR_DIAG_STAT = 16'h1f3d;
    localparam logic [15:0] ADDR_DIAG_PARAM = 16'h1f3e;
    localparam logic [15:0] ADDR_IN_WORD = 16'h1f40;
    localparam logic [15:0] ADDR_OUT_WORD = 16'h2328;

    // ------------------------------------------------------------
    // Function codes and exception codes
    // ------------------------------------------------------------
    localparam logic [7:0] FC_RD_COILS = 8'h01;
    localparam logic [7:0] FC_RD_DISCR = 8'h02;
    localparam logic [7:0] FC_RD_HOLD = 8'h03;
    localparam logic [7:0] FC_RD_INPUT = 8'h04;
    localparam logic [7:0] FC_WR_COIL = 8'h05;
    localparam logic [7:0] FC_WR_REG = 8'h06;
    localparam logic [7:0] FC_WR_COILS = 8'h0f;
    localparam logic [7:0] FC_WR_REGS = 8'h10;
    localparam logic [7:0] FC_RW_REGS = 8'h17;
    localparam logic [7:0] EXC_NONE = 8'h00;
    localparam logic [7:0] EXC_BAD_FC = 8'h01;
    localparam logic [7:0] EXC_BAD_ADDR = 8'h02;
    localparam logic [7:0] EXC_BAD_VALUE = 8'h03;

    // ------------------------------------------------------------
    // Field values, causes, commands, reset values
    // ------------------------------------------------------------
    localparam logic [15:0] TMO_OFF = 16'h0000;
    localparam logic [15:0] TMO_MIN_MS = 16'h00c8;
    localparam logic [15:0] TMO_MAX_MS = 16'hfde8;
    localparam logic [15:0] MODE_LOW = 16'h0000;
    localparam logic [15:0] MODE_HIGH = 16'h0001;
    localparam logic [15:0] MODE_HOLD = 16'h0002;
    localparam logic [15:0] CAUSE_NONE = 16'h0000;
    localparam logic [15:0] CAUSE_XFER_IF = 16'h0007;
    localparam logic [15:0] CAUSE_HOST = 16'h0008;
    localparam logic [15:0] CAUSE_USER = 16'h0009;
    localparam logic [15:0] CAUSE_ABORT = 16'h000a;
    localparam logic [15:0] CAUSE_INIT = 16'h000b;
    localparam logic [15:0] CAUSE_WDOG = 16'h000c;
    localparam logic [15:0] CAUSE_CONN_TMO = 16'h000d;
    localparam logic [15:0] CMD_SET_FAIL = 16'h0010;
    localparam logic [15:0] CMD_ACK_FAIL = 16'h0020;
    localparam logic [15:0] CMD_CLR_WARN = 16'h0080;
    localparam int unsigned STAT_ERR_BIT = 0;
    localparam int unsigned STAT_FAIL_BIT = 1;
    localparam int unsigned NUM_CONN = 8;
    localparam int unsigned NUM_DOUT = 4;
    localparam logic [15:0] WORD_RST = 16'h0000;

    // ------------------------------------------------------------
    // Timebase
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned MS_IN_NS = 1000000;
    localparam int unsigned MS_CYCLES_DFLT = MS_IN_NS / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic [2:0] conn;
        logic [7:0] fc;
        logic [15:0] addr;
        logic [3:0] bit_idx;
        logic [15:0] wdata;
    } fbio_req_t;

    typedef struct packed {
        logic valid;
        logic [2:0] conn;
        logic [7:0] exc;
        logic [15:0] rdata;
    } fbio_rsp_t;

    typedef struct packed {
        logic xfer_if_tmo;
        logic host_tmo;
        logic conn_abort;
        logic init_err;
    } fbio_evt_t;

endpackage

// File: rtl/fbio_ms_tick.sv
// Millisecond timebase: one-cycle tick every CYCLES clocks
`timescale 1ns/1ns
module fbio_ms_tick
    import fbio_pkg::*;
#(
    parameter int unsigned CYCLES = MS_CYCLES_DFLT
)
(
    input wire logic mclk_in,
    input wire logic rstn_in,
    output logic tick_out
);

    logic [31:0] cnt_ff;

    always_ff @(posedge mclk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            cnt_ff <= 32'h0;
            tick_out <= 1'b0;
        end
        else if (cnt_ff == 32'(CYCLES - 1))
        begin
            cnt_ff <= 32'h0;
            tick_out <= 1'b1;
        end
        else
        begin
            cnt_ff <= cnt_ff + 32'h1;
            tick_out <= 1'b0;
        end
    end

endmodule

// File: verification/fbio_client.sv
// Client partner model: one register request at a time, answer sampled one cycle later
`timescale 1ns/1ns
module fbio_client
    import fbio_pkg::*;
(
    input wire logic mclk_in,
    output fbio_req_t req_out,
    input wire fbio_rsp_t rsp_in
);
    initial req_out = '0;
    // Valid is held for exactly the taking edge, then released
    task automatic xfer(input logic [7:0] fc, input logic [15:0] a, input logic [15:0] d,
        output logic [7:0] e, output logic [15:0] r);
        @(posedge mclk_in);
        req_out <= '{1'b1, 3'h0, fc, a, 4'h0, d};
        @(posedge mclk_in);
        req_out.valid <= 1'b0;
        @(posedge mclk_in);
        e = rsp_in.valid ? rsp_in.exc : 8'hff;
        r = rsp_in.rdata;
    endtask
endmodule

// File: verification/testbench.sv
// Self-checking bench for the fieldbus I/O register bank
`timescale 1ns/1ns
module testbench;
    import fbio_pkg::*;
    logic mclk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic [7:0] din_in = 8'h00;
    fbio_req_t req;
    fbio_rsp_t rsp;
    logic [3:0] dout;
    logic nf;
    logic warn;
    logic auto_ack = 1'b0;
    logic [15:0] diag = 16'h0000;
    logic [7:0] e;
    logic [15:0] r;
    logic [15:0] w;
    logic [31:0] seed = 32'h0000004f;
    int failures = 0;
    int checks_done = 0;
    int cyc = 0;
    always #5 mclk_in = ~mclk_in;
    fbio_regbank #(.MS_CYCLES(10)) i_fbio_regbank(.mclk_in(mclk_in), .rstn_in(rstn_in),
        .req_in(req), .rsp_out(rsp), .din_in(din_in), .evt_in('0), .conn_close_in('0),
        .auto_ack_in(auto_ack), .diag_status_in(diag), .diag_param_in(16'h0000),
        .dout_out(dout), .net_fail_out(nf), .io_warn_out(warn));
    fbio_client i_fbio_client(.mclk_in(mclk_in), .req_out(req), .rsp_in(rsp));
    function automatic logic [31:0] xs(logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    function automatic logic [15:0] exp_dout(logic [15:0] m, logic [15:0] wd);
        return (m == MODE_LOW) ? 16'h0000 : (m == MODE_HIGH) ? 16'h000f : {12'h000, wd[3:0]};
    endfunction
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            failures++;
            $display("Error at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic acc(input logic [7:0] fc, input logic [15:0] a, input logic [15:0] d);
        i_fbio_client.xfer(fc, a, d, e, r);
    endtask
    task automatic final_report();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Hang guard: the whole run needs about 2280 cycles
    // ------------------------------------------------------------
    always @(posedge mclk_in)
    begin
        cyc <= cyc + 1;
        if (cyc == 8000)
        begin
            failures++;
            final_report();
        end
    end
    initial
    begin
        repeat (20) @(posedge mclk_in);
        rstn_in <= 1'b1;
        acc(FC_RD_HOLD, ADDR_WDOG_TMO, 16'h0000);
        chk(r, 16'h0000);
        acc(FC_RD_INPUT, ADDR_FAULT_SEL, 16'h0000);
        chk(r, MODE_LOW);
        $display("reset values done");
        for (int i = 0; i < 4; i++)
        begin
            seed = xs(seed);
            w = seed[15:0];
            din_in <= seed[23:16];
            acc(FC_WR_REG, ADDR_OUT_WORD, w);
            acc(FC_RD_HOLD, ADDR_OUT_WORD, 16'h0000);
            chk(r, w);
            acc(FC_RD_INPUT, ADDR_IN_WORD, 16'h0000);
            chk(r, {8'h00, seed[23:16]});
            acc(FC_RD_DISCR, ADDR_IN_WORD, 16'h0000);
            chk(r, {15'h0000, seed[16]});
            chk({12'h000, dout}, {12'h000, w[3:0]});
        end
        $display("process data done");
        acc(FC_WR_REG, ADDR_CAUSE, 16'h0001);
        chk({8'h00, e}, 16'h0002);
        acc(8'h07, ADDR_OUT_WORD, 16'h0000);
        chk({8'h00, e}, 16'h0001);
        acc(FC_WR_REG, ADDR_COMMAND, 16'h0030);
        chk({8'h00, e}, 16'h0003);
        acc(FC_RD_HOLD, ADDR_STATUS, 16'h0000);
        chk(r, 16'h0000);
        $display("refusals done");
        for (logic [15:0] m = 16'h0000; m < 16'h0003; m++)
        begin
            acc(FC_WR_REG, ADDR_FAULT_SEL, m);
            acc(FC_WR_REG, ADDR_COMMAND, CMD_SET_FAIL);
            acc(FC_RD_HOLD, ADDR_CAUSE, 16'h0000);
            chk(r, CAUSE_USER);
            acc(FC_RD_HOLD, ADDR_STATUS, 16'h0000);
            chk(r, 16'h0002);
            chk({12'h000, dout}, exp_dout(m, w));
            chk({15'h0000, nf}, 16'h0001);
            acc(FC_WR_REG, ADDR_COMMAND, CMD_ACK_FAIL);
            acc(FC_RD_HOLD, ADDR_STATUS, 16'h0000);
            chk(r, 16'h0000);
        end
        $display("fault modes done");
        auto_ack <= 1'b1;
        acc(FC_WR_REG, ADDR_COMMAND, CMD_SET_FAIL);
        acc(FC_WR_REG, ADDR_OUT_WORD, w);
        acc(FC_RD_HOLD, ADDR_STATUS, 16'h0000);
        chk(r, 16'h0000);
        chk({12'h000, dout}, {12'h000, w[3:0]});
        auto_ack <= 1'b0;
        diag <= 16'h0001;
        @(posedge mclk_in);
        diag <= 16'h0000;
        acc(FC_RD_HOLD, ADDR_STATUS, 16'h0000);
        chk(r, 16'h0001);
        chk({15'h0000, warn}, 16'h0001);
        acc(FC_WR_REG, ADDR_COMMAND, CMD_CLR_WARN);
        acc(FC_RD_HOLD, ADDR_STATUS, 16'h0000);
        chk(r, 16'h0000);
        chk({15'h0000, warn}, 16'h0000);
        $display("acknowledge and warning done");
        acc(FC_WR_REG, ADDR_CONN_MON, TMO_OFF);
        // Only legal timeout values are written by this client
        acc(FC_WR_REG, ADDR_WDOG_TMO, TMO_MIN_MS);
        acc(FC_WR_REG, ADDR_OUT_WORD, w);
        repeat (1000) @(posedge mclk_in);
        acc(FC_RD_HOLD, ADDR_OUT_WORD, 16'h0000);
        chk(r, 16'h0000 ^ w);
        repeat (1100) @(posedge mclk_in);
        acc(FC_RD_HOLD, ADDR_CAUSE, 16'h0000);
        chk(r, CAUSE_WDOG);
        acc(FC_RD_HOLD, ADDR_STATUS, 16'h0000);
        chk(r, 16'h0002);
        $display("watchdog done");
        final_report();
    end
endmodule
